// File: wwd_pkg.sv
/*
 Shared constants of the window watchdog: oscillator period counts,
 reset pulse and glitch filter times, state encoding.
 Assumes a single 250 MHz system clock.
*/
package wwd_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TRIG_MIN_NS = 200;
	localparam int unsigned TRIG_MIN_CYC = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int unsigned LEAD_PERIODS = 7895;
	localparam int unsigned CLOSED_PERIODS = 1053;
	localparam int unsigned OPEN_PERIODS = 1105;
	localparam int unsigned NRES_MS = 4;
	localparam int unsigned NRES_CYC = NRES_MS * CLK_MHZ * 1000;
	localparam int unsigned OSC_US_X100 = 1960;
	localparam int unsigned OSC_CYC = OSC_US_X100 * CLK_MHZ / 100;
	localparam int unsigned FALLBACK_OSC_CYC = 4 * OSC_CYC;
	localparam int unsigned SYNC_STAGES = 3;
	typedef enum logic [2:0] {
		WWD_RESET,
		WWD_LEAD,
		WWD_CLOSED,
		WWD_OPEN,
		WWD_OFF
	} wwd_state_t;
endpackage

// File: wwd_sync.sv
/*
 Three-stage synchroniser with agreement check for asynchronous pins.
 Assumes inputs come from outside the clk_i domain.
*/
module wwd_sync
	import wwd_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic async_i,
	output logic sync_o
);
	logic [SYNC_STAGES-1:0] stage_reg;
	logic [SYNC_STAGES-1:0] stage_next;
	logic out_reg;
	logic out_next;

	always_comb begin
		stage_next = {stage_reg[SYNC_STAGES-2:0], async_i};
		out_next = out_reg;
		// First stage feeds only the second; stages two and three must agree
		if (stage_reg[1] == stage_reg[2]) begin
			out_next = stage_reg[2];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage_reg <= {SYNC_STAGES{RST_VAL}};
			out_reg <= RST_VAL;
		end else begin
			stage_reg <= stage_next;
			out_reg <= out_next;
		end
	end

	assign sync_o = out_reg;
endmodule

// File: wwd_top.sv
/*
 Window watchdog: lead time, closed and open windows, fixed reset pulse
 on an open-drain reset output. Timing from an oscillator tick derived
 from clk_i. Assumes mode, disable, receive data and pin fault status
 come from surrounding device logic or pins.
*/
// Contract
// R1: Falling trigger edge is the watchdog event.
// R2: Low pulses not over 200 ns ignored.
// R3: Intervals counted in oscillator periods.
// R4: Silent or Sleep disables watchdog entirely.
// R5: Lead time starts at reset release.
// R6: After wake, lead starts at receive falling.
// R7: Power-up holds reset low about 4 ms.
// R8: Trigger in lead starts closed window.
// R9: Lead expiry gives 4 ms reset pulse.
// R10: Trigger in open window restarts closed.
// R11: Open window expiry gives 4 ms reset.
// R12: Trigger in closed window resets at once.
// R13: Host triggers between closed max and sum.
// R14: Resistor fault uses internal fallback oscillator.
// R15: Reset low forces Fail-safe mode.
// R16: Disable input suppresses all watchdog resets.
module wwd_top
	import wwd_pkg::*;
#(
	parameter int unsigned NRES_CYCLES = NRES_CYC,
	parameter int unsigned OSC_CYCLES = OSC_CYC,
	parameter int unsigned FALLBACK_CYCLES = FALLBACK_OSC_CYC,
	parameter int unsigned LEAD_P = LEAD_PERIODS,
	parameter int unsigned CLOSED_P = CLOSED_PERIODS,
	parameter int unsigned OPEN_P = OPEN_PERIODS
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic trigger_n_i,
	input wire logic rxd_i,
	input wire logic low_power_i,
	input wire logic wd_disable_i,
	input wire logic timing_resistor_fault_i,
	input wire logic reset_pin_i,
	output logic reset_o,
	output logic reset_oe_o,
	output logic failsafe_o,
	output wwd_state_t state_o
);
	localparam int CW = 24;
	localparam int PW = 14;

	logic trig_s;
	logic rxd_s;
	logic lp_s;
	logic dis_s;
	logic fault_s;

	wwd_sync #(.RST_VAL(1'b1)) u_trig (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.async_i(trigger_n_i), .sync_o(trig_s));
	wwd_sync #(.RST_VAL(1'b1)) u_rxd (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.async_i(rxd_i), .sync_o(rxd_s));
	wwd_sync #(.RST_VAL(1'b0)) u_lp (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.async_i(low_power_i), .sync_o(lp_s));
	wwd_sync #(.RST_VAL(1'b0)) u_dis (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.async_i(wd_disable_i), .sync_o(dis_s));
	wwd_sync #(.RST_VAL(1'b0)) u_flt (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.async_i(timing_resistor_fault_i), .sync_o(fault_s));

	wwd_state_t state_reg;
	wwd_state_t state_next;
	logic [CW-1:0] rst_cnt_reg;
	logic [CW-1:0] rst_cnt_next;
	logic [CW-1:0] osc_cnt_reg;
	logic [CW-1:0] osc_cnt_next;
	logic [PW-1:0] per_cnt_reg;
	logic [PW-1:0] per_cnt_next;
	logic [7:0] low_cnt_reg;
	logic [7:0] low_cnt_next;
	logic trig_prev_reg;
	logic trig_prev_next;
	logic armed_reg;
	logic armed_next;
	logic rxd_prev_reg;
	logic rxd_prev_next;
	logic wake_pend_reg;
	logic wake_pend_next;
	logic drive_reg;
	logic drive_next;

	logic osc_tick;
	logic trig_evt;
	logic rxd_fall;
	logic [CW-1:0] osc_limit;

	function automatic logic [PW-1:0] to_pw(input int unsigned v);
		to_pw = PW'(v - 1);
	endfunction

	// Fallback oscillator keeps a reset guaranteed when the resistor pin fails
	assign osc_limit = fault_s ? CW'(FALLBACK_CYCLES - 1) : CW'(OSC_CYCLES - 1); // R14
	assign osc_tick = (osc_cnt_reg == osc_limit);
	assign rxd_fall = rxd_prev_reg && !rxd_s;

	always_comb begin
		osc_cnt_next = osc_tick ? '0 : osc_cnt_reg + CW'(1); // R3
		trig_prev_next = trig_s;
		low_cnt_next = low_cnt_reg;
		armed_next = armed_reg;
		trig_evt = 1'b0;
		// Edge counts only once the low level outlasts the glitch limit
		if (trig_prev_reg && !trig_s) begin // R1
			low_cnt_next = 8'h00;
			armed_next = 1'b1;
		end else if (!trig_s && armed_reg) begin
			low_cnt_next = low_cnt_reg + 8'h01;
			// Fires on the last of TRIG_MIN_CYC low cycles, so 204 ns is taken
			if (low_cnt_reg == 8'(TRIG_MIN_CYC - 2)) begin // R2
				trig_evt = 1'b1;
				armed_next = 1'b0;
			end
		end else if (trig_s) begin
			armed_next = 1'b0;
		end
		if (state_reg == WWD_OFF || state_reg == WWD_RESET) begin
			osc_cnt_next = '0;
		end
	end

	always_comb begin
		state_next = state_reg;
		rst_cnt_next = rst_cnt_reg;
		per_cnt_next = per_cnt_reg;
		drive_next = drive_reg;
		rxd_prev_next = rxd_s;
		wake_pend_next = wake_pend_reg;
		case (state_reg)
			WWD_RESET: begin
				drive_next = 1'b1;
				if (rst_cnt_reg == CW'(NRES_CYCLES - 1)) begin // R7
					drive_next = 1'b0;
					state_next = WWD_LEAD; // R5
					per_cnt_next = to_pw(LEAD_P);
					rst_cnt_next = '0;
				end else begin
					rst_cnt_next = rst_cnt_reg + CW'(1);
				end
			end
			WWD_LEAD: begin
				if (trig_evt) begin
					state_next = WWD_CLOSED; // R8
					per_cnt_next = to_pw(CLOSED_P);
				end else if (osc_tick) begin
					if (per_cnt_reg == '0) begin
						state_next = dis_s ? WWD_LEAD : WWD_RESET; // R9 R16
						per_cnt_next = to_pw(LEAD_P);
					end else begin
						per_cnt_next = per_cnt_reg - PW'(1);
					end
				end
			end
			WWD_CLOSED: begin
				if (trig_evt && !dis_s) begin
					state_next = WWD_RESET; // R12
				end else if (trig_evt) begin
					per_cnt_next = to_pw(CLOSED_P);
				end else if (osc_tick) begin
					if (per_cnt_reg == '0) begin
						state_next = WWD_OPEN;
						per_cnt_next = to_pw(OPEN_P);
					end else begin
						per_cnt_next = per_cnt_reg - PW'(1);
					end
				end
			end
			WWD_OPEN: begin
				if (trig_evt) begin
					state_next = WWD_CLOSED; // R10
					per_cnt_next = to_pw(CLOSED_P);
				end else if (osc_tick) begin
					if (per_cnt_reg == '0) begin
						state_next = dis_s ? WWD_CLOSED : WWD_RESET; // R11 R16
						per_cnt_next = to_pw(CLOSED_P);
					end else begin
						per_cnt_next = per_cnt_reg - PW'(1);
					end
				end
			end
			WWD_OFF: begin
				drive_next = 1'b0;
				if (!lp_s) begin
					wake_pend_next = 1'b1;
				end
				// Lead time waits for the wake indication on receive data
				if ((wake_pend_reg || !lp_s) && rxd_fall) begin // R6
					state_next = WWD_LEAD;
					per_cnt_next = to_pw(LEAD_P);
					wake_pend_next = 1'b0;
				end
			end
			default: begin
				state_next = WWD_RESET;
			end
		endcase
		if (lp_s) begin
			state_next = WWD_OFF; // R4
			drive_next = 1'b0;
			wake_pend_next = 1'b0;
			rst_cnt_next = '0;
		end
		if (state_next == WWD_RESET && state_reg != WWD_RESET) begin
			rst_cnt_next = '0;
			drive_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= WWD_RESET;
			rst_cnt_reg <= '0;
			osc_cnt_reg <= '0;
			per_cnt_reg <= '0;
			low_cnt_reg <= 8'h00;
			trig_prev_reg <= 1'b1;
			armed_reg <= 1'b0;
			rxd_prev_reg <= 1'b1;
			wake_pend_reg <= 1'b0;
			drive_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			rst_cnt_reg <= rst_cnt_next;
			osc_cnt_reg <= osc_cnt_next;
			per_cnt_reg <= per_cnt_next;
			low_cnt_reg <= low_cnt_next;
			trig_prev_reg <= trig_prev_next;
			armed_reg <= armed_next;
			rxd_prev_reg <= rxd_prev_next;
			wake_pend_reg <= wake_pend_next;
			drive_reg <= drive_next;
		end
	end

	// Open drain: only ever pulls low
	assign reset_o = 1'b0;
	assign reset_oe_o = drive_reg;
	// Pin may be held low externally too; either way fail-safe follows
	assign failsafe_o = drive_reg || !reset_pin_i; // R15
	assign state_o = state_reg;
endmodule

// File: wwd_host.sv
/*
 Host model: drives the trigger pin low for a commanded number of cycles,
 and resolves the open-drain reset wire with its pull-up.
 Assumes commands arrive just after a rising clock edge.
*/
module wwd_host (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] len_i,
	input wire logic reset_oe_i,
	output logic trigger_n_o,
	output logic reset_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_reg = 0;
	always @(posedge clk_i) begin
		if (go_i) begin
			cnt_reg <= len_i;
		end else if (cnt_reg > 0) begin
			cnt_reg <= cnt_reg - 1;
		end
	end
	assign trigger_n_o = (cnt_reg == 0);
	// Pull-up wins whenever the device lets go
	assign reset_pin_o = !reset_oe_i;
endmodule

// File: wwd_chk_sva.sv
/*
 Port-level checks of the window watchdog.
 Assumes binding onto wwd_top with its own parameters.
*/
module wwd_chk
	import wwd_pkg::*;
#(
	parameter int unsigned NRES_CYCLES = 20,
	parameter int unsigned OSC_CYCLES = 4,
	parameter int unsigned FALLBACK_CYCLES = 16,
	parameter int unsigned LEAD_P = 40,
	parameter int unsigned CLOSED_P = 20,
	parameter int unsigned OPEN_P = 20
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic trigger_n_i,
	input wire logic low_power_i,
	input wire logic wd_disable_i,
	input wire logic timing_resistor_fault_i,
	input wire logic reset_pin_i,
	input wire logic reset_o,
	input wire logic reset_oe_o,
	input wire logic failsafe_o,
	input wire wwd_state_t state_o
);
	wwd_state_t prev_reg;
	int cnt_reg;
	int low_reg;
	int hi_reg;
	int osc;
	// Tick phase is free, so window lengths get one period of slack
	assign osc = timing_resistor_fault_i ? FALLBACK_CYCLES : OSC_CYCLES;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_reg <= WWD_RESET;
			cnt_reg <= 0;
			low_reg <= 0;
			hi_reg <= 0;
		end else begin
			prev_reg <= state_o;
			cnt_reg <= (state_o != prev_reg) ? 1 : cnt_reg + 1;
			// Latest low run is kept a while: the synchroniser lags the pin
			low_reg <= trigger_n_i ? low_reg : ((hi_reg != 0) ? 1 : low_reg + 1);
			hi_reg <= trigger_n_i ? hi_reg + 1 : 0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_FAILSAFE: assert property (failsafe_o == (reset_oe_o || !reset_pin_i))
		else $error("failsafe mismatch");
	AST_OE_STATE: assert property (reset_oe_o == (state_o == WWD_RESET) && !reset_o)
		else $error("reset drive mismatch");
	AST_PULSE: assert property (prev_reg == WWD_RESET && state_o == WWD_LEAD
		|-> cnt_reg inside {[NRES_CYCLES:NRES_CYCLES + 1]}) else $error("pulse width");
	AST_PWRUP: assert property ($fell(sys_rst_i) |-> reset_oe_o [*8] ##[1:40]
		state_o == WWD_LEAD) else $error("power-up sequence");
	AST_OFF: assert property (low_power_i [*8] |-> state_o == WWD_OFF && !reset_oe_o)
		else $error("low power not off");
	AST_HELD: assert property ($rose(state_o == WWD_CLOSED) && !wd_disable_i
		|-> low_reg >= TRIG_MIN_CYC && hi_reg < 8) else $error("short trigger taken");
	AST_EARLY: assert property (prev_reg == WWD_CLOSED && state_o == WWD_RESET
		|-> low_reg >= TRIG_MIN_CYC && hi_reg < 8) else $error("closed reset without trigger");
	AST_LEAD: assert property (prev_reg == WWD_LEAD && state_o == WWD_RESET |->
		!wd_disable_i && cnt_reg inside {[(LEAD_P - 1) * osc + 1:LEAD_P * osc + 1]})
		else $error("lead length");
	AST_CLOSED: assert property (prev_reg == WWD_CLOSED && state_o == WWD_OPEN
		|-> cnt_reg inside {[(CLOSED_P - 1) * osc + 1:CLOSED_P * osc + 1]})
		else $error("closed length");
endmodule
bind wwd_top wwd_chk #(.NRES_CYCLES(NRES_CYCLES), .OSC_CYCLES(OSC_CYCLES),
	.FALLBACK_CYCLES(FALLBACK_CYCLES), .LEAD_P(LEAD_P), .CLOSED_P(CLOSED_P),
	.OPEN_P(OPEN_P)) chk (.clk_i, .sys_rst_i, .trigger_n_i, .low_power_i, .wd_disable_i,
	.timing_resistor_fault_i, .reset_pin_i, .reset_o, .reset_oe_o, .failsafe_o, .state_o);

// File: wwd_bench.sv
/*
 Bench of the window watchdog: host model on the trigger pin, state
 changes compared in order with a queue of expectations.
 Assumes wwd_pkg, the host model and the checker compiled first.
*/
module wwd_bench
	import wwd_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0;
	logic sys_rst_i = 1;
	logic go = 0;
	logic [7:0] len = 0;
	logic rxd_i = 1;
	logic low_power_i = 0;
	logic wd_disable_i = 0;
	logic timing_resistor_fault_i = 0;
	logic trigger_n_i, reset_pin_i, reset_o, reset_oe_o, failsafe_o;
	wwd_state_t state_o;
	wwd_state_t prev = WWD_RESET;
	wwd_state_t exp_st = WWD_RESET;
	wwd_state_t q[$];
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	bit [31:0] seed = 32'h0000EA3B;
	initial forever #2 clk_i = ~clk_i;
	wwd_host host (.clk_i, .go_i(go), .len_i(len), .reset_oe_i(reset_oe_o),
		.trigger_n_o(trigger_n_i), .reset_pin_o(reset_pin_i));
	// Short periods keep the run small; open window keeps its full length
	wwd_top #(.NRES_CYCLES(20), .OSC_CYCLES(4), .FALLBACK_CYCLES(16), .LEAD_P(40),
		.CLOSED_P(20)) dut (.clk_i, .sys_rst_i, .trigger_n_i, .rxd_i,
		.low_power_i, .wd_disable_i, .timing_resistor_fault_i, .reset_pin_i, .reset_o,
		.reset_oe_o, .failsafe_o, .state_o);
	function automatic int rnd(int m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % m);
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_st(wwd_state_t s);
		for (int i = 0; i < 6000 && state_o !== s; i++) tick(1);
		if (state_o !== s) failures++;
	endtask
	task automatic trig(int l);
		len <= 8'(l);
		go <= 1;
		tick(1);
		go <= 0;
	endtask
	task automatic expire;
		q.push_back(WWD_RESET);
		q.push_back(WWD_LEAD);
		wait_st(WWD_RESET);
		wait_st(WWD_LEAD);
	endtask
	task automatic done(int n);
		$display("test %0d done at %0t", n, $time);
	endtask
	task automatic chk(wwd_state_t e, wwd_state_t g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_bit(logic e, logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(negedge clk_i) begin
		cyc++;
		if (!sys_rst_i && state_o !== prev) begin
			exp_st = q.size() > 0 ? q.pop_front() : prev;
			chk(exp_st, state_o);
			chk_bit(exp_st == WWD_RESET, reset_oe_o);
			chk_bit(exp_st == WWD_RESET || !reset_pin_i, failsafe_o);
		end
		prev = state_o;
		if (cyc > 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		tick(20);
		sys_rst_i <= 0;
		q.push_back(WWD_LEAD);
		wait_st(WWD_LEAD);
		tick(rnd(20));
		trig(60 + rnd(8));
		q.push_back(WWD_CLOSED);
		q.push_back(WWD_OPEN);
		wait_st(WWD_OPEN);
		trig(60 + rnd(8));
		q.push_back(WWD_CLOSED);
		q.push_back(WWD_OPEN);
		wait_st(WWD_CLOSED);
		wait_st(WWD_OPEN);
		expire();
		done(1);
		trig(50);
		expire();
		done(2);
		tick(rnd(20));
		q.push_back(WWD_CLOSED);
		trig(51);
		tick(64);
		trig(60 + rnd(8));
		timing_resistor_fault_i <= 1;
		expire();
		done(3);
		q.push_back(WWD_RESET);
		wait_st(WWD_RESET);
		timing_resistor_fault_i <= 0;
		q.push_back(WWD_LEAD);
		wait_st(WWD_LEAD);
		done(4);
		wd_disable_i <= 1;
		tick(400);
		low_power_i <= 1;
		q.push_back(WWD_OFF);
		wait_st(WWD_OFF);
		wd_disable_i <= 0;
		tick(200);
		done(5);
		low_power_i <= 0;
		tick(10);
		rxd_i <= 0;
		q.push_back(WWD_LEAD);
		wait_st(WWD_LEAD);
		rxd_i <= 1;
		expire();
		done(6);
		close_out();
	end
endmodule
